// ===== src/bsi_instr_decode.sv
`timescale 1ns/100ps
// What this block does
// - sample captures pin snapshot without disturbing operation
// - preload fills update stages before external test
// - external test drives update values, captures inputs
// - external test: enabled keeper beats tri-state value
// - bypass: one-bit register between data in and out
// - user signature: 32-bit register shifted out
// - signature default until configured, then configured value
// - identification: load 32-bit code and shift out
// - identification active at power-up and test reset
// - tri-state instruction floats pins, selects bypass
// - tri-state after configuration: keeper takes priority
// - clamp holds update values, keeper wins after configuration
// - reconfig instruction emulates configuration request low pulse
// - io config instruction opens io settings chain
// - four test pins only, no test reset
module bsi_instr_decode
    import bsi_pkg::*;
#(
    parameter int NUM_PINS = 8,
    parameter logic [31:0] IDCODE_VALUE = 32'h1000_0001 // arbitrary value
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdoEn,
    input wire logic configDone,
    input wire logic [31:0] userSig,
    input wire logic [NUM_PINS-1:0] coreOut,
    input wire logic [NUM_PINS-1:0] coreOe,
    input wire logic [NUM_PINS-1:0] keeperEn,
    input wire logic [NUM_PINS-1:0] padIn,
    output logic [NUM_PINS-1:0] padOut,
    output logic [NUM_PINS-1:0] padOe,
    output logic [NUM_PINS-1:0] padPull,
    output logic reconfigReq_n,
    output logic ioChainShift,
    output logic ioChainTdi,
    input wire logic ioChainTdo
);

    localparam int BSC_LEN = CELLS_PER_PIN * NUM_PINS;
    localparam int XW = 3 + BSC_LEN;
    localparam int PW = RECONF_PULSE_CYC;
    localparam int PWM1 = RECONF_PULSE_CYC - 1;
    localparam logic [7:0] PULSE_CNT = 8'(RECONF_PULSE_CYC);

    // ---------------- link side (tck) ----------------
    logic tckRstMeta;
    logic rstTck_n;
    bsi_tap_e state;
    bsi_tap_e next_state;
    logic [IR_LEN-1:0] irShift;
    logic [IR_LEN-1:0] irActive;
    bsi_dr_e drSel;
    bsi_pinmode_s pinMode;
    logic bypassReg;
    logic [SIG_LEN-1:0] idShift;
    logic [BSC_LEN-1:0] bscShift;
    logic [BSC_LEN-1:0] bscUpd;
    logic [BSC_LEN-1:0] capRaw;
    logic [BSC_LEN-1:0] capS1, capS2, capS3, capVal;
    logic cfgS1, cfgS2, cfgS3, cfgDoneT;
    logic serialOut;
    logic [XW-1:0] xferWord;
    logic xferTgl;
    logic rcfgTgl;

    // power-on reset only, released on tck; no test reset pin exists
    always_ff @(posedge tck or negedge reset_n) begin
        if (!reset_n) begin
            tckRstMeta <= 1'b0;
            rstTck_n <= 1'b0;
        end else begin
            tckRstMeta <= 1'b1;
            rstTck_n <= tckRstMeta;
        end
    end

    // tap controller
    always_comb begin
        next_state = state;
        unique case (state)
            TAP_RESET: next_state = tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: next_state = tms ? SEL_DR : TAP_IDLE;
            SEL_DR: next_state = tms ? SEL_IR : CAP_DR;
            CAP_DR: next_state = tms ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: next_state = tms ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: next_state = tms ? UPD_DR : PAUSE_DR;
            PAUSE_DR: next_state = tms ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: next_state = tms ? UPD_DR : SHIFT_DR;
            UPD_DR: next_state = tms ? SEL_DR : TAP_IDLE;
            SEL_IR: next_state = tms ? TAP_RESET : CAP_IR;
            CAP_IR: next_state = tms ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: next_state = tms ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: next_state = tms ? UPD_IR : PAUSE_IR;
            PAUSE_IR: next_state = tms ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: next_state = tms ? UPD_IR : SHIFT_IR;
            UPD_IR: next_state = tms ? SEL_DR : TAP_IDLE;
        endcase
    end

    always_ff @(posedge tck or negedge rstTck_n) begin
        if (!rstTck_n) begin
            state <= TAP_RESET;
        end else begin
            state <= next_state;
        end
    end

    // instruction register
    always_ff @(posedge tck or negedge rstTck_n) begin
        if (!rstTck_n) begin
            irShift <= IR_CAPTURE_VAL;
            irActive <= OP_IDENT;
        end else begin
            if (state == CAP_IR) begin
                irShift <= IR_CAPTURE_VAL;
            end else if (state == SHIFT_IR) begin
                irShift <= {tdi, irShift[IR_LEN-1:1]};
            end
            if (next_state == TAP_RESET) begin
                irActive <= OP_IDENT;
            end else if (state == UPD_IR) begin
                irActive <= irShift;
            end
        end
    end

    // instruction decode
    always_comb begin
        drSel = DR_BYPASS;
        pinMode = '0;
        unique case (irActive)
            OP_SAMPLE: drSel = DR_BOUNDARY;
            OP_EXTEST: begin
                drSel = DR_BOUNDARY;
                pinMode.drive = 1'b1;
            end
            OP_BYPASS: drSel = DR_BYPASS;
            OP_USERSIG: drSel = DR_SIGNATURE;
            OP_IDENT: drSel = DR_SIGNATURE;
            OP_HIGHZ: pinMode.highz = 1'b1;
            OP_CLAMP: pinMode.clamp = 1'b1;
            OP_IOCFG: drSel = DR_IOCHAIN;
            default: drSel = DR_BYPASS;
        endcase
    end

    // pin and config status synchronisers on tck
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            capRaw[CELLS_PER_PIN*i+CELL_IN] = padIn[i];
            capRaw[CELLS_PER_PIN*i+CELL_OUT] = coreOut[i];
            capRaw[CELLS_PER_PIN*i+CELL_OE] = coreOe[i];
        end
    end

    always_ff @(posedge tck or negedge rstTck_n) begin
        if (!rstTck_n) begin
            {capS1, capS2, capS3, capVal} <= '0;
            {cfgS1, cfgS2, cfgS3, cfgDoneT} <= '0;
        end else begin
            capS1 <= capRaw;
            capS2 <= capS1;
            capS3 <= capS2;
            if (capS2 == capS3) begin
                capVal <= capS3;
            end
            cfgS1 <= configDone;
            cfgS2 <= cfgS1;
            cfgS3 <= cfgS2;
            if (cfgS2 == cfgS3) begin
                cfgDoneT <= cfgS3;
            end
        end
    end

    // data registers
    always_ff @(posedge tck or negedge rstTck_n) begin
        if (!rstTck_n) begin
            bypassReg <= 1'b0;
            idShift <= '0;
            bscShift <= '0;
        end else if (state == CAP_DR) begin
            bypassReg <= 1'b0;
            if (irActive == OP_IDENT) begin
                idShift <= IDCODE_VALUE;
            end else begin
                idShift <= cfgDoneT ? userSig : USERSIG_DEFAULT;
            end
            bscShift <= capVal;
        end else if (state == SHIFT_DR) begin
            bypassReg <= tdi;
            if (drSel == DR_SIGNATURE) begin
                idShift <= {tdi, idShift[SIG_LEN-1:1]};
            end
            if (drSel == DR_BOUNDARY) begin
                bscShift <= {tdi, bscShift[BSC_LEN-1:1]};
            end
        end
    end

    // update stages, loaded by sample/preload or external test
    always_ff @(posedge tck or negedge rstTck_n) begin
        if (!rstTck_n) begin
            bscUpd <= '0;
        end else if (state == UPD_DR && drSel == DR_BOUNDARY) begin
            bscUpd <= bscShift;
        end
    end

    // io settings chain access
    always_ff @(posedge tck or negedge rstTck_n) begin
        if (!rstTck_n) begin
            ioChainShift <= 1'b0;
            ioChainTdi <= 1'b0;
        end else begin
            ioChainShift <= (state == SHIFT_DR) && (drSel == DR_IOCHAIN);
            ioChainTdi <= tdi;
        end
    end

    // serial output on falling tck
    always_comb begin
        serialOut = bypassReg;
        if (state == SHIFT_IR) begin
            serialOut = irShift[0];
        end else begin
            unique case (drSel)
                DR_BYPASS: serialOut = bypassReg;
                DR_SIGNATURE: serialOut = idShift[0];
                DR_BOUNDARY: serialOut = bscShift[0];
                DR_IOCHAIN: serialOut = ioChainTdo;
                default: serialOut = bypassReg;
            endcase
        end
    end

    always_ff @(negedge tck or negedge rstTck_n) begin
        if (!rstTck_n) begin
            tdo <= 1'b0;
            tdoEn <= 1'b0;
        end else begin
            tdo <= serialOut;
            tdoEn <= (state == SHIFT_DR) || (state == SHIFT_IR);
        end
    end

    // crossing toward mclk on falling tck, so an update lands before the link clock stops
    always_ff @(negedge tck or negedge rstTck_n) begin
        if (!rstTck_n) begin
            xferWord <= '0;
            xferTgl <= 1'b0;
            rcfgTgl <= 1'b0;
        end else begin
            xferWord <= {pinMode, bscUpd};
            if ({pinMode, bscUpd} != xferWord) begin
                xferTgl <= ~xferTgl;
            end
            if (state == UPD_IR && irShift == OP_RECONFIG) begin
                rcfgTgl <= ~rcfgTgl;
            end
        end
    end

    // ---------------- core side (mclk) ----------------
    logic [2:0] xfS;
    logic xfLast;
    logic [2:0] rcS;
    logic rcLast;
    logic xfSeen;
    logic rcfgSeen;
    bsi_pinmode_s pinModeM;
    logic [BSC_LEN-1:0] bscUpdM;
    logic [NUM_PINS-1:0] updOutM;
    logic [NUM_PINS-1:0] updOeM;
    logic [7:0] pulseCnt;

    assign xfSeen = (xfS[1] == xfS[2]) && (xfS[2] != xfLast);
    assign rcfgSeen = (rcS[1] == rcS[2]) && (rcS[2] != rcLast);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            xfS <= '0;
            rcS <= '0;
            xfLast <= 1'b0;
            rcLast <= 1'b0;
        end else begin
            xfS <= {xfS[1:0], xferTgl};
            rcS <= {rcS[1:0], rcfgTgl};
            if (xfS[1] == xfS[2]) begin
                xfLast <= xfS[2];
            end
            if (rcS[1] == rcS[2]) begin
                rcLast <= rcS[2];
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pinModeM <= '0;
            bscUpdM <= '0;
        end else if (xfSeen) begin
            {pinModeM, bscUpdM} <= xferWord;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            updOutM[i] = bscUpdM[CELLS_PER_PIN*i+CELL_OUT];
            updOeM[i] = bscUpdM[CELLS_PER_PIN*i+CELL_OE];
        end
    end

    // pin drive selection
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            padOut <= '0;
            padOe <= '0;
            padPull <= '0;
        end else if (pinModeM.drive) begin
            padOut <= updOutM;
            padOe <= updOeM;
            padPull <= keeperEn & ~updOeM;
        end else if (pinModeM.highz) begin
            padOut <= '0;
            padOe <= '0;
            padPull <= configDone ? keeperEn : '0;
        end else if (pinModeM.clamp) begin
            padOut <= updOutM;
            padOe <= configDone ? (updOeM & ~keeperEn) : updOeM;
            padPull <= configDone ? keeperEn : '0;
        end else begin
            padOut <= coreOut;
            padOe <= coreOe;
            padPull <= keeperEn;
        end
    end

    // reconfiguration request, pin itself untouched
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pulseCnt <= '0;
            reconfigReq_n <= 1'b1;
        end else if (rcfgSeen) begin
            pulseCnt <= PULSE_CNT;
            reconfigReq_n <= 1'b0;
        end else if (pulseCnt != '0) begin
            pulseCnt <= pulseCnt - 8'h01;
            reconfigReq_n <= (pulseCnt == 8'h01);
        end
    end

    // ---------------- checks ----------------
    property p_tlr_ident;
        @(posedge tck) disable iff (!rstTck_n) tms [*5] |=> (state == TAP_RESET) && (irActive == OP_IDENT);
    endproperty
    a_tlr_ident: assert property (p_tlr_ident) else $error("ident not active after test reset");

    property p_ir_update;
        @(posedge tck) disable iff (!rstTck_n) (state == UPD_IR) && !tms |=> irActive == $past(irShift);
    endproperty
    a_ir_update: assert property (p_ir_update) else $error("opcode not applied at update-ir");

    property p_bypass_delay;
        @(posedge tck) disable iff (!rstTck_n)
            (state == SHIFT_DR) && (drSel == DR_BYPASS) |=> (bypassReg == $past(tdi)) ##0 (serialOut == bypassReg);
    endproperty
    a_bypass_delay: assert property (p_bypass_delay) else $error("bypass not one stage");

    property p_ident_capture;
        @(posedge tck) disable iff (!rstTck_n)
            (state == CAP_DR) && (irActive == OP_IDENT) |=> (idShift == IDCODE_VALUE) && (drSel == DR_SIGNATURE);
    endproperty
    a_ident_capture: assert property (p_ident_capture) else $error("ident code not loaded");

    property p_usersig_capture;
        @(posedge tck) disable iff (!rstTck_n)
            (state == CAP_DR) && (irActive == OP_USERSIG)
            |=> idShift == ($past(cfgDoneT) ? $past(userSig) : USERSIG_DEFAULT);
    endproperty
    a_usersig_capture: assert property (p_usersig_capture) else $error("wrong user signature");

    property p_preload;
        @(posedge tck) disable iff (!rstTck_n) (state == UPD_DR) && (drSel == DR_BOUNDARY) |=> bscUpd == $past(bscShift);
    endproperty
    a_preload: assert property (p_preload) else $error("update stage not loaded");

    property p_iochain;
        @(posedge tck) disable iff (!rstTck_n) (state == SHIFT_DR) && (irActive == OP_IOCFG) |=> ioChainShift;
    endproperty
    a_iochain: assert property (p_iochain) else $error("io chain not shifted");

    property p_extest_drive;
        @(posedge mclk) disable iff (!reset_n)
            pinModeM.drive |=> (padOe == $past(updOeM)) && (padOut == $past(updOutM))
            && (padPull == ($past(keeperEn) & ~$past(updOeM)));
    endproperty
    a_extest_drive: assert property (p_extest_drive) else $error("extest drive wrong");

    property p_highz;
        @(posedge mclk) disable iff (!reset_n) pinModeM.highz && !pinModeM.drive |=> padOe == '0;
    endproperty
    a_highz: assert property (p_highz) else $error("pins not floated");

    property p_clamp_keeper;
        @(posedge mclk) disable iff (!reset_n)
            pinModeM.clamp && !pinModeM.drive && configDone |=> (padOe & padPull) == '0;
    endproperty
    a_clamp_keeper: assert property (p_clamp_keeper) else $error("keeper lost to clamp");

    property p_normal_pins;
        @(posedge mclk) disable iff (!reset_n)
            pinModeM == '0 |=> (padOe == $past(coreOe)) && (padOut == $past(coreOut));
    endproperty
    a_normal_pins: assert property (p_normal_pins) else $error("normal pins disturbed");

    property p_reconfig_pulse;
        @(posedge mclk) disable iff (!reset_n)
            rcfgSeen |=> !reconfigReq_n ##[PWM1:PWM1] !reconfigReq_n ##1 reconfigReq_n;
    endproperty
    a_reconfig_pulse: assert property (p_reconfig_pulse) else $error("reconfig pulse width wrong");

    c_extest: cover property (@(posedge tck) disable iff (!rstTck_n) state == UPD_IR && irShift == OP_EXTEST);
    c_usersig: cover property (@(posedge tck) disable iff (!rstTck_n) state == SHIFT_DR && irActive == OP_USERSIG);
    c_reconfig: cover property (@(posedge mclk) disable iff (!reset_n) rcfgSeen ##1 !reconfigReq_n ##[PW:PW] reconfigReq_n);
    c_highz: cover property (@(posedge mclk) disable iff (!reset_n) pinModeM.highz);

endmodule

// ===== src/bsi_pkg.sv
package bsi_pkg;

    // instruction register
    localparam int IR_LEN = 10;
    localparam logic [9:0] OP_SAMPLE = 10'h005;
    localparam logic [9:0] OP_EXTEST = 10'h00f;
    localparam logic [9:0] OP_BYPASS = 10'h3ff;
    localparam logic [9:0] OP_USERSIG = 10'h007;
    localparam logic [9:0] OP_IDENT = 10'h006;
    localparam logic [9:0] OP_HIGHZ = 10'h00b;
    localparam logic [9:0] OP_CLAMP = 10'h00a;
    localparam logic [9:0] OP_RECONFIG = 10'h001;
    localparam logic [9:0] OP_IOCFG = 10'h00d;
    localparam logic [9:0] IR_CAPTURE_VAL = 10'h001;

    // data registers
    localparam int SIG_LEN = 32;
    localparam logic [31:0] USERSIG_DEFAULT = 32'hffff_ffff;

    // boundary cell layout, per pin
    localparam int CELLS_PER_PIN = 3;
    localparam int CELL_IN = 0;
    localparam int CELL_OUT = 1;
    localparam int CELL_OE = 2;

    // reconfiguration request pulse on mclk
    localparam int MCLK_MHZ = 100;
    localparam int RECONF_PULSE_NS = 200;
    localparam int RECONF_PULSE_CYC = (RECONF_PULSE_NS * MCLK_MHZ + 999) / 1000;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
        SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
    } bsi_tap_e;

    typedef enum logic [2:0] {
        DR_BYPASS, DR_SIGNATURE, DR_BOUNDARY, DR_IOCHAIN
    } bsi_dr_e;

    typedef struct packed {
        logic drive;
        logic clamp;
        logic highz;
    } bsi_pinmode_s;

endpackage

// ===== verification/boundary_scan_instruction_decode_tb.sv
`timescale 1ns/100ps
module boundary_scan_instruction_decode_tb;
    import bsi_pkg::*;
    localparam logic [31:0] IDV = 32'h2468_ace1; // arbitrary value
    logic mclk, reset_n, tck, tms, tdi, tdo, tdoEn, configDone;
    logic reconfigReq_n, ioChainShift, ioChainTdi, ioChainTdo;
    logic [31:0] userSig, r;
    logic [7:0] coreOut, coreOe, keeperEn, padIn, padOut, padOe, padPull;
    logic [23:0] p;
    logic [15:0] chainBits;
    int enCnt = 0;
    logic [31:0] expQ[$];
    logic [31:0] mskQ[$];
    int err_total = 0;
    int num_checks = 0;
    int lowCnt = 0;
    int shiftCnt = 0;

    bsi_instr_decode #(.NUM_PINS(8), .IDCODE_VALUE(IDV)) dut (.mclk(mclk), .reset_n(reset_n),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn), .configDone(configDone),
        .userSig(userSig), .coreOut(coreOut), .coreOe(coreOe), .keeperEn(keeperEn), .padIn(padIn),
        .padOut(padOut), .padOe(padOe), .padPull(padPull), .reconfigReq_n(reconfigReq_n),
        .ioChainShift(ioChainShift), .ioChainTdi(ioChainTdi), .ioChainTdo(ioChainTdo));
    bsi_jtag_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(negedge mclk) begin
        if (reconfigReq_n === 1'b0) lowCnt++;
    end
    always @(negedge tck) begin
        if (ioChainShift === 1'b1) begin
            shiftCnt++;
            chainBits = {ioChainTdi, chainBits[15:1]};
        end
    end
    always @(posedge tck) begin
        if (tdoEn === 1'b1) enCnt++;
    end
    always @(negedge mclk) begin
        ioChainTdo <= 1'($urandom);
    end

    task automatic summarize();
        if (err_total == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cmpWord(input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: shifted word expected %h got %h", $time, e, g);
        end
    endtask
    task automatic cmpPin(input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: pin value expected %h got %h", $time, e, g);
        end
    endtask
    task automatic dr(input int n, input logic [31:0] din, input logic [31:0] e, input logic [31:0] m);
        expQ.push_back(e & m);
        mskQ.push_back(m);
        host.scan(1'b0, n, din);
    endtask
    task automatic ir(input logic [9:0] op);
        expQ.push_back({22'h0, IR_CAPTURE_VAL});
        mskQ.push_back(32'h0000_03ff);
        host.scan(1'b1, IR_LEN, {22'h0, op});
    endtask
    task automatic pins(input logic [7:0] eo, input logic [7:0] eoe, input logic [7:0] ep);
        repeat (25) @(negedge mclk);
        cmpPin({24'h0, eoe}, {24'h0, padOe});
        cmpPin({24'h0, eo & eoe}, {24'h0, padOut & eoe});
        cmpPin({24'h0, ep}, {24'h0, padPull});
    endtask
    task automatic bypassCheck();
        r = $urandom;
        dr(32, r, {r[30:0], 1'b0}, 32'hffff_ffff);
    endtask
    function automatic logic [7:0] cellBits(input logic [23:0] v, input int k);
        for (int i = 0; i < 8; i++) cellBits[i] = v[3 * i + k];
    endfunction
    function automatic logic [31:0] spread(input logic [7:0] v);
        spread = '0;
        for (int i = 0; i < 8; i++) spread[3 * i + CELL_IN] = v[i];
    endfunction

    // result watcher: each shifted word against the oldest note
    initial begin
        logic [31:0] g;
        forever begin
            wait (host.gotQ.size() > 0);
            g = host.gotQ.pop_front();
            cmpWord(expQ.pop_front(), g & mskQ.pop_front());
        end
    end
    initial begin
        #400us;
        err_total++;
        summarize();
    end

    initial begin
        reset_n = 1'b1;
        configDone = 1'b0;
        ioChainTdo = 1'b0;
        void'($urandom(32'h95e8));
        userSig = $urandom;
        coreOut = 8'($urandom);
        coreOe = 8'($urandom);
        keeperEn = 8'($urandom);
        padIn = 8'($urandom);
        @(negedge mclk);
        reset_n = 1'b0;
        repeat (6) @(negedge mclk);
        reset_n = 1'b1;
        host.home();
        dr(32, $urandom, IDV, 32'hffff_ffff);
        ir(OP_USERSIG);
        dr(32, $urandom, USERSIG_DEFAULT, 32'hffff_ffff);
        @(negedge mclk);
        configDone = 1'b1;
        repeat (10) @(negedge mclk);
        ir(OP_USERSIG);
        dr(32, $urandom, userSig, 32'hffff_ffff);
        ir(OP_BYPASS);
        bypassCheck();
        ir(10'h100 | 10'($urandom % 256));
        bypassCheck();
        pins(coreOut, coreOe, keeperEn);
        ir(OP_SAMPLE);
        p = 24'($urandom);
        dr(24, {8'h0, p}, spread(padIn), 32'h0024_9249);
        pins(coreOut, coreOe, keeperEn);
        ir(OP_EXTEST);
        pins(cellBits(p, CELL_OUT), cellBits(p, CELL_OE), keeperEn & ~cellBits(p, CELL_OE));
        ir(OP_CLAMP);
        bypassCheck();
        pins(cellBits(p, CELL_OUT), cellBits(p, CELL_OE) & ~keeperEn, keeperEn);
        ir(OP_HIGHZ);
        bypassCheck();
        pins(8'h00, 8'h00, keeperEn);
        lowCnt = 0;
        ir(OP_RECONFIG);
        repeat (60) @(negedge mclk);
        cmpPin(RECONF_PULSE_CYC, lowCnt);
        ir(OP_IOCFG);
        shiftCnt = 0;
        enCnt = 0;
        r = $urandom;
        dr(16, r, 32'h0, 32'h0);
        cmpPin(32'd16, shiftCnt);
        cmpPin({16'h0, r[15:0]}, {16'h0, chainBits});
        cmpPin(32'd16, enCnt);
        ir(OP_IDENT);
        dr(32, $urandom, IDV, 32'hffff_ffff);
        ir(OP_BYPASS);
        host.home();
        dr(32, $urandom, IDV, 32'hffff_ffff);
        repeat (5) @(negedge mclk);
        summarize();
    end
endmodule

// ===== verification/bsi_jtag_host.sv
`timescale 1ns/100ps
// external test controller; the link clock rests low between frames
module bsi_jtag_host (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    logic [31:0] gotQ[$];
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // one 80 ns link cycle, tdo taken at the rising edge
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #40;
        o = tdo;
        tck = 1'b1;
        #40;
        tck = 1'b0;
    endtask
    // no test reset pin: five high tms edges, then idle
    task automatic home();
        logic o;
        #3;
        for (int i = 0; i < 6; i++) begin
            step(i < 5, 1'b1, o);
        end
    endtask
    // from idle: shift n bits lsb first, back to idle, note what came out
    task automatic scan(input logic isIr, input int n, input logic [31:0] din);
        logic [31:0] dout;
        logic o;
        dout = '0;
        #3;
        step(1'b1, 1'b1, o);
        if (isIr) step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        tdi = 1'b1;
        gotQ.push_back(dout);
    endtask
endmodule
